// *** gp_timer_cmp_map.svh ***
// Purpose: Register offsets, field positions and reset values of the timer compare and interrupt block.
// Assumes: Byte addresses on a 32-bit word-aligned register port.
// Notes: Definitions only; included by bare name.
`ifndef GP_TIMER_CMP_MAP_SVH
`define GP_TIMER_CMP_MAP_SVH

// Register byte addresses.
`define ADDR_COMPARE_C_LOW 32'h40000020
`define ADDR_COMPARE_C_HIGH 32'h40000024
`define ADDR_IRQ_ENABLE 32'h40000028
`define ADDR_IRQ_STATUS 32'h4000002C
`define ADDR_IRQ_CLEAR 32'h40000030

// Reset values.
`define RST_COMPARE_C_LOW 16'h3FFF
`define RST_COMPARE_C_HIGH 16'h0000
`define RST_IRQ_ENABLE 16'h0000

// Field positions; bits 0 to 3 are shared by enable, status and clear registers, freeze and enable-sync are status only.
`define BIT_MATCH_A 0
`define BIT_MATCH_B 1
`define BIT_MATCH_C 2
`define BIT_ROLL 3
`define BIT_FREEZE 7
`define BIT_EN_SYNC 8

// Number of sticky event flags.
`define NUM_FLAGS 4

`endif

// *** gp_timer_pkg.sv ***
// Purpose: Shared types of the timer compare and interrupt block.
// Assumes: Constants live in gp_timer_cmp_map.svh.
// Notes: Nothing here is imported; users write gp_timer_pkg::name.
package gp_timer_pkg;
   typedef logic [15:0] half_t;
   typedef logic [31:0] word_t;
   typedef logic [3:0] flag_vec_t;
endpackage

// *** gp_sticky_flag.sv ***
// Purpose: One sticky event flag with a clear request carried to the slow tick.
// Assumes: slow_tick is a one-cycle enable marking an edge of the 32.768 kHz count domain.
// Notes: A set in the tick that applies a clear wins, so no event is lost.
`timescale 1ns/10ps
module gp_sticky_flag (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic slow_tick,
   input wire logic set_event,
   input wire logic clr_write,
   output logic flag_reg,
   output logic clr_pend_reg
);

   // The clear write is held until the slow domain takes it, then drops by itself.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         clr_pend_reg <= 1'b0;
      end else if (clr_write) begin
         clr_pend_reg <= 1'b1;
      end else if (slow_tick) begin
         clr_pend_reg <= 1'b0;
      end
   end

   // The flag moves only on the slow tick; a fresh event beats a pending clear.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         flag_reg <= 1'b0;
      end else if (slow_tick) begin
         flag_reg <= set_event | (flag_reg & ~clr_pend_reg);
      end
   end

endmodule

// *** gp_timer_compare_irq.sv ***
// Purpose: Compare field C, interrupt enables, sticky status and write-one clear of a 32-bit timer.
// Assumes: Counter, mode bits and enable come from neighbouring logic on mclk; slow_tick marks count edges.
// Notes: Matches and clears act on slow_tick, the 32.768 kHz rate seen as an enable on mclk.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`include "gp_timer_cmp_map.svh"
module gp_timer_compare_irq (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [31:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rd_data,
   input wire logic slow_tick,
   input wire logic [31:0] counter_value,
   input wire logic [31:0] compare_a_value,
   input wire logic [31:0] compare_b_value,
   input wire logic free_run,
   input wire logic count_down,
   input wire logic timer_enable,
   input wire logic freeze_enable,
   input wire logic high_frozen,
   output logic counter_restart,
   output logic counter_run,
   output logic irq
);

   gp_timer_pkg::half_t compare_c_low_reg;
   gp_timer_pkg::half_t compare_c_high_reg;
   gp_timer_pkg::half_t irq_enable_reg;
   gp_timer_pkg::word_t compare_c_value;
   gp_timer_pkg::flag_vec_t flag_set;
   gp_timer_pkg::flag_vec_t flag_clr_wr;
   gp_timer_pkg::flag_vec_t flags;
   gp_timer_pkg::flag_vec_t clr_pend;
   gp_timer_pkg::half_t status_word;
   logic run_reg;
   logic en_sync_reg;
   logic freeze_reg;
   logic wr_clear;
   logic reach_c;
   logic roll_point;

   assign compare_c_value = {compare_c_high_reg, compare_c_low_reg};
   assign wr_clear = wr_stb && (addr == `ADDR_IRQ_CLEAR);
   assign reach_c = (counter_value == compare_c_value);
   assign roll_point = count_down ? (counter_value == 32'h00000000) : (counter_value == 32'hFFFFFFFF);

   // Field C halves are writable at any time; the software side keeps periodic writes to a stopped timer.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         compare_c_low_reg <= `RST_COMPARE_C_LOW;
         compare_c_high_reg <= `RST_COMPARE_C_HIGH;
      end else if (wr_stb) begin
         if (addr == `ADDR_COMPARE_C_LOW) begin
            compare_c_low_reg <= wr_data;
         end
         if (addr == `ADDR_COMPARE_C_HIGH) begin
            compare_c_high_reg <= wr_data;
         end
      end
   end

   // Only the four defined enable bits are kept; upper bits are dropped so stray ones cannot gate anything.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         irq_enable_reg <= `RST_IRQ_ENABLE;
      end else if (wr_stb && (addr == `ADDR_IRQ_ENABLE)) begin
         irq_enable_reg <= {12'h000, wr_data[3:0]};
      end
   end

   // The enable is taken into the count domain on a slow tick; until then the change shows as pending.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         run_reg <= 1'b0;
      end else if (slow_tick) begin
         run_reg <= timer_enable;
      end
   end

   // Pending-enable status compares the bus-side enable with the copy the count domain holds.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         en_sync_reg <= 1'b0;
      end else begin
         en_sync_reg <= timer_enable != (slow_tick ? timer_enable : run_reg);
      end
   end

   // Freeze status follows the upper-half latch only while freezing is switched on.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         freeze_reg <= 1'b0;
      end else begin
         freeze_reg <= freeze_enable && high_frozen;
      end
   end

   // Each comparison runs only with its enable set and the timer running.
   always_comb begin
      flag_set = 4'h0;
      flag_set[`BIT_MATCH_A] = run_reg && irq_enable_reg[`BIT_MATCH_A] && (counter_value == compare_a_value);
      flag_set[`BIT_MATCH_B] = run_reg && irq_enable_reg[`BIT_MATCH_B] && (counter_value == compare_b_value);
      flag_set[`BIT_MATCH_C] = run_reg && irq_enable_reg[`BIT_MATCH_C] && reach_c;
      flag_set[`BIT_ROLL] = run_reg && irq_enable_reg[`BIT_ROLL] && free_run && roll_point;
   end

   assign flag_clr_wr = wr_clear ? wr_data[3:0] : 4'h0;

   // One sticky flag per event; the clear request rides with the flag until the slow tick.
   for (genvar i = 0; i < `NUM_FLAGS; i++) begin : g_flag
      gp_sticky_flag u_flag (
         .mclk(mclk),
         .rst_b(rst_b),
         .slow_tick(slow_tick),
         .set_event(flag_set[i]),
         .clr_write(flag_clr_wr[i]),
         .flag_reg(flags[i]),
         .clr_pend_reg(clr_pend[i])
      );
   end

   // Periodic restart fires on field C regardless of the match enable, otherwise the period would die with it.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         counter_restart <= 1'b0;
      end else begin
         counter_restart <= slow_tick && run_reg && !free_run && reach_c;
      end
   end

   // The counter core is held in reset until the enable has reached the count domain.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         counter_run <= 1'b0;
      end else begin
         counter_run <= run_reg;
      end
   end

   // Interrupt request is one cycle behind the flags so the output comes from a flip-flop.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |flags;
      end
   end

   // Status image; reserved bits read zero.
   always_comb begin
      status_word = 16'h0000;
      status_word[3:0] = flags;
      status_word[`BIT_FREEZE] = freeze_reg;
      status_word[`BIT_EN_SYNC] = en_sync_reg;
   end

   // Read data stand in the cycle after the strobe only; the clear register and unmapped space read zero.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rd_data <= 16'h0000;
      end else if (rd_stb) begin
         unique case (addr)
            `ADDR_COMPARE_C_LOW: rd_data <= compare_c_low_reg;
            `ADDR_COMPARE_C_HIGH: rd_data <= compare_c_high_reg;
            `ADDR_IRQ_ENABLE: rd_data <= irq_enable_reg;
            `ADDR_IRQ_STATUS: rd_data <= status_word;
            default: rd_data <= 16'h0000;
         endcase
      end else begin
         rd_data <= 16'h0000;
      end
   end

   // Checks on the behaviour above.
   property p_restart_on_c;
      @(posedge mclk) disable iff (!rst_b)
      slow_tick && run_reg && !free_run && reach_c |=> counter_restart;
   endproperty
   a_restart_on_c: assert property (p_restart_on_c) else $error("No restart at field C.");

   property p_no_restart_free;
      @(posedge mclk) disable iff (!rst_b)
      free_run && !$past(free_run) == 1'b0 && free_run |=> !counter_restart;
   endproperty
   a_no_restart_free: assert property (p_no_restart_free) else $error("Restart in free-running mode.");

   property p_c_low_write;
      @(posedge mclk) disable iff (!rst_b)
      wr_stb && (addr == `ADDR_COMPARE_C_LOW) |=> compare_c_low_reg == $past(wr_data);
   endproperty
   a_c_low_write: assert property (p_c_low_write) else $error("Field C low write lost.");

   property p_c_gate;
      @(posedge mclk) disable iff (!rst_b)
      !irq_enable_reg[`BIT_MATCH_C] && !flags[`BIT_MATCH_C] |=> !flags[`BIT_MATCH_C];
   endproperty
   a_c_gate: assert property (p_c_gate) else $error("C flag set while disabled.");

   property p_roll_gate;
      @(posedge mclk) disable iff (!rst_b)
      !irq_enable_reg[`BIT_ROLL] && !flags[`BIT_ROLL] |=> !flags[`BIT_ROLL];
   endproperty
   a_roll_gate: assert property (p_roll_gate) else $error("Roll flag set while disabled.");

   property p_match_b_sets;
      @(posedge mclk) disable iff (!rst_b)
      slow_tick && run_reg && irq_enable_reg[`BIT_MATCH_B] && (counter_value == compare_b_value)
         |=> flags[`BIT_MATCH_B] ##1 irq;
   endproperty
   a_match_b_sets: assert property (p_match_b_sets) else $error("B match did not raise flag and irq.");

   property p_roll_sets;
      @(posedge mclk) disable iff (!rst_b)
      slow_tick && run_reg && irq_enable_reg[`BIT_ROLL] && free_run && !count_down
         && (counter_value == 32'hFFFFFFFF) |=> flags[`BIT_ROLL];
   endproperty
   a_roll_sets: assert property (p_roll_sets) else $error("Rollover flag not set.");

   property p_flag_holds;
      @(posedge mclk) disable iff (!rst_b)
      flags[`BIT_MATCH_A] && !clr_pend[`BIT_MATCH_A] && !flag_clr_wr[`BIT_MATCH_A] |=> flags[`BIT_MATCH_A];
   endproperty
   a_flag_holds: assert property (p_flag_holds) else $error("Flag A dropped without a clear.");

   property p_clear_applies;
      @(posedge mclk) disable iff (!rst_b)
      slow_tick && clr_pend[`BIT_MATCH_A] && !flag_set[`BIT_MATCH_A] && !flag_clr_wr[`BIT_MATCH_A]
         |=> !flags[`BIT_MATCH_A] && !clr_pend[`BIT_MATCH_A];
   endproperty
   a_clear_applies: assert property (p_clear_applies) else $error("Clear A not applied once.");

   property p_clear_kept;
      @(posedge mclk) disable iff (!rst_b)
      flag_clr_wr[`BIT_MATCH_C] |=> clr_pend[`BIT_MATCH_C];
   endproperty
   a_clear_kept: assert property (p_clear_kept) else $error("Clear C request lost.");

   property p_en_sync;
      @(posedge mclk) disable iff (!rst_b)
      (timer_enable != run_reg) && !slow_tick |=> en_sync_reg;
   endproperty
   a_en_sync: assert property (p_en_sync) else $error("Enable change not shown pending.");

   property p_freeze;
      @(posedge mclk) disable iff (!rst_b)
      freeze_enable && high_frozen |=> freeze_reg;
   endproperty
   a_freeze: assert property (p_freeze) else $error("Freeze status missing.");

   property p_hold_reset;
      @(posedge mclk) disable iff (!rst_b)
      !run_reg |=> !counter_run && !counter_restart;
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("Timer ran while disabled.");

   property p_irq_level;
      @(posedge mclk) disable iff (!rst_b)
      (flags == 4'h0) |=> !irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("Irq high with no flag.");

   property p_enable_read;
      @(posedge mclk) disable iff (!rst_b)
      rd_stb && (addr == `ADDR_IRQ_ENABLE) |=> rd_data == {12'h000, $past(irq_enable_reg[3:0])};
   endproperty
   a_enable_read: assert property (p_enable_read) else $error("Enable readback wrong.");

   c_restart: cover property (@(posedge mclk) disable iff (!rst_b) counter_restart);
   c_set_and_clear: cover property (@(posedge mclk) disable iff (!rst_b)
      slow_tick && flag_set[`BIT_MATCH_A] && clr_pend[`BIT_MATCH_A]);
   c_roll: cover property (@(posedge mclk) disable iff (!rst_b) flags[`BIT_ROLL]);
   c_en_sync: cover property (@(posedge mclk) disable iff (!rst_b) $fell(en_sync_reg));

endmodule

// *** tb.sv ***
// Purpose: Self-checking bench for the timer compare and interrupt block.
// Assumes: The bench stands in for the counter core and makes slow_tick itself.
// Notes: A small model of flags, pending clears and the run copy predicts every status read.
`timescale 1ns/10ps
`include "gp_timer_cmp_map.svh"
module tb;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [31:0] addr = 32'h00000000;
   logic [15:0] wr_data = 16'h0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic slow_tick = 1'b0;
   gp_timer_pkg::word_t counter_value = 32'h00000000;
   gp_timer_pkg::word_t compare_a_value = 32'h00000000;
   gp_timer_pkg::word_t compare_b_value = 32'h00000000;
   logic free_run = 1'b0;
   logic count_down = 1'b0;
   logic timer_enable = 1'b0;
   logic freeze_enable = 1'b0;
   logic high_frozen = 1'b0;
   logic [15:0] rd_data;
   logic counter_restart;
   logic counter_run;
   logic irq;
   int mismatches = 0;
   int samples_checked = 0;
   gp_timer_pkg::word_t ca, cb, cc, cnt;
   gp_timer_pkg::flag_vec_t flags_m = 4'h0;
   gp_timer_pkg::flag_vec_t pend_m = 4'h0;
   logic [15:0] ien_m = 16'h0000;
   logic run_m = 1'b0;
   logic [15:0] rd;
   int sel;

   gp_timer_compare_irq dut_u (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rd_data(rd_data), .slow_tick(slow_tick), .counter_value(counter_value),
      .compare_a_value(compare_a_value), .compare_b_value(compare_b_value), .free_run(free_run),
      .count_down(count_down), .timer_enable(timer_enable), .freeze_enable(freeze_enable),
      .high_frozen(high_frozen), .counter_restart(counter_restart), .counter_run(counter_run), .irq(irq));

   // Free-running 40 MHz clock.
   always #12.5 mclk = ~mclk;

   task automatic stop_test;
      $display("Counts: mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   // A write also updates the bench model, so expectations never come from the design.
   task automatic bus_wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
      if (a == `ADDR_IRQ_ENABLE) ien_m = {12'h000, d[3:0]};
      if (a == `ADDR_IRQ_CLEAR) pend_m = pend_m | d[3:0];
      if (a == `ADDR_COMPARE_C_LOW) cc[15:0] = d;
      if (a == `ADDR_COMPARE_C_HIGH) cc[31:16] = d;
   endtask

   task automatic bus_rd(input logic [31:0] a, output logic [15:0] d);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask

   function automatic logic [15:0] exp_status();
      return {7'h00, timer_enable != run_m, freeze_enable & high_frozen, 3'h0, flags_m};
   endfunction

   // Events are judged with the run copy from before this tick, since the slow side lags.
   function automatic gp_timer_pkg::flag_vec_t events(input gp_timer_pkg::word_t v);
      gp_timer_pkg::flag_vec_t e;
      e[0] = ien_m[0] && v == ca;
      e[1] = ien_m[1] && v == cb;
      e[2] = ien_m[2] && v == cc;
      e[3] = ien_m[3] && free_run && (count_down ? v == 32'h00000000 : v == 32'hFFFFFFFF);
      return run_m ? e : 4'h0;
   endfunction

   task automatic status_chk;
      bus_rd(`ADDR_IRQ_STATUS, rd);
      chk16(rd, exp_status(), "status");
   endtask

   // One slow-domain tick with the given count; a set in the tick beats a pending clear.
   task automatic step(input gp_timer_pkg::word_t v, input logic fr, input logic dn);
      gp_timer_pkg::flag_vec_t ev;
      logic rs;
      @(posedge mclk);
      counter_value <= v;
      free_run <= fr;
      count_down <= dn;
      slow_tick <= 1'b1;
      #1 ev = events(v);
      // A stopped timer must never restart, so the check runs on every tick.
      rs = run_m && !fr && v == cc;
      @(posedge mclk);
      slow_tick <= 1'b0;
      #1 chk1(counter_restart, rs, "restart");
      flags_m = (flags_m & ~pend_m) | ev;
      pend_m = 4'h0;
      run_m = timer_enable;
      @(posedge mclk);
      #1 chk1(counter_restart, 1'b0, "restart width");
      chk1(irq, |flags_m, "irq");
   endtask

   // Watchdog against a hang.
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      stop_test();
   end

   // Main sequence.
   initial begin
      void'($urandom(45986));
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      #1 chk1(irq, 1'b0, "irq reset");
      bus_rd(`ADDR_COMPARE_C_LOW, rd);
      chk16(rd, `RST_COMPARE_C_LOW, "c low reset");
      @(posedge mclk);
      #1 chk16(rd_data, 16'h0000, "idle read data");
      bus_rd(`ADDR_COMPARE_C_HIGH, rd);
      chk16(rd, `RST_COMPARE_C_HIGH, "c high reset");
      bus_rd(`ADDR_IRQ_ENABLE, rd);
      chk16(rd, `RST_IRQ_ENABLE, "enable reset");
      status_chk();
      bus_rd(`ADDR_IRQ_CLEAR, rd);
      chk16(rd, 16'h0000, "clear read");
      bus_rd(32'h40000034, rd);
      chk16(rd, 16'h0000, "unmapped read");
      chk1(counter_run, 1'b0, "run held");
      ca = $urandom;
      cb = $urandom;
      @(posedge mclk);
      compare_a_value <= ca;
      compare_b_value <= cb;
      cc = 32'h00000000;
      // Field C is written while stopped, with the pending-enable bit seen low and the C enable clear.
      bus_wr(`ADDR_COMPARE_C_LOW, 16'($urandom));
      bus_wr(`ADDR_COMPARE_C_HIGH, 16'($urandom));
      bus_rd(`ADDR_COMPARE_C_LOW, rd);
      chk16(rd, cc[15:0], "c low");
      bus_rd(`ADDR_COMPARE_C_HIGH, rd);
      chk16(rd, cc[31:16], "c high");
      bus_wr(`ADDR_IRQ_ENABLE, 16'hFFFF);
      bus_rd(`ADDR_IRQ_ENABLE, rd);
      chk16(rd, 16'h000F, "enable upper bits");
      bus_wr(`ADDR_IRQ_ENABLE, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         {freeze_enable, high_frozen} <= 2'(i);
         status_chk();
      end
      // Enable change is flagged until the slow domain takes it.
      @(posedge mclk);
      timer_enable <= 1'b1;
      status_chk();
      step($urandom, 1'b1, 1'b0);
      status_chk();
      chk1(counter_run, 1'b1, "run follows enable");
      bus_wr(`ADDR_COMPARE_C_HIGH, 16'($urandom));
      bus_rd(`ADDR_COMPARE_C_HIGH, rd);
      chk16(rd, cc[31:16], "c high while running");
      // Random events, enables and clears; the count lands on fields and rollover points often.
      for (int n = 0; n < 80; n++) begin
         sel = $urandom_range(5);
         cnt = sel == 0 ? ca : sel == 1 ? cb : sel == 2 ? cc : sel == 3 ? 32'h00000000 :
            sel == 4 ? 32'hFFFFFFFF : $urandom;
         if ($urandom_range(2) == 0) bus_wr(`ADDR_IRQ_ENABLE, {12'h000, 4'($urandom)});
         if ($urandom_range(2) == 0) bus_wr(`ADDR_IRQ_CLEAR, {12'h000, 4'($urandom)});
         status_chk();
         step(cnt, 1'($urandom), 1'($urandom));
         status_chk();
      end
      // Disable: one last tick still runs, then matches stop.
      bus_wr(`ADDR_IRQ_ENABLE, 16'h000F);
      bus_wr(`ADDR_IRQ_CLEAR, 16'h000F);
      @(posedge mclk);
      timer_enable <= 1'b0;
      status_chk();
      step(ca, 1'b0, 1'b0);
      step(cb, 1'b0, 1'b0);
      status_chk();
      chk1(counter_run, 1'b0, "run dropped");
      stop_test();
   end
endmodule
